// >>> core/pwm_pair_pkg.sv
// constants and carrier types for the master/slave pwm channel pair
// assumes one system clock; count ticks arrive as a synchronous enable
package pwm_pair_pkg;

    // ==========================================================
    // widths
    localparam int CNT_W  = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_START   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STOP    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ENABLE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PERIOD  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_DUTY    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_MCOUNT  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SCOUNT  = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_OUTCTRL = 8'h1c;

    // ==========================================================
    // field positions
    localparam int BIT_MASTER = 0;
    localparam int BIT_SLAVE  = 1;
    localparam int BIT_LEVEL  = 0;
    localparam int BIT_OUTEN  = 1;
    localparam int BIT_POL    = 2;

    // ==========================================================
    // values after reset and fixed counter values
    localparam logic [CNT_W-1:0] CNT_ONES   = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'h0000;
    localparam logic [CNT_W-1:0] DUTY_RST   = 16'h0000;
    localparam logic [CNT_W-1:0] MCOUNT_RST = 16'hffff;
    localparam logic [CNT_W-1:0] SCOUNT_RST = 16'hffff;
    localparam logic [2:0]       OUTCTL_RST = 3'h0;
    localparam logic [1:0]       ENABLE_RST = 2'h0;

    // ==========================================================
    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } regReq_t;

endpackage : pwm_pair_pkg

// >>> core/pwm_pair.sv
// master/slave pwm channel pair: period counter, duty counter, output pin
// assumes a plain register port and a synchronous one-cycle count tick

module pwm_pair (
    // clock and reset
    input  wire logic                            clk_sys,
    input  wire logic                            rst,
    // count clock tick
    input  wire logic                            countClockTick,
    // register port
    input  wire pwm_pair_pkg::regReq_t           regReq,
    output logic [pwm_pair_pkg::DATA_W-1:0]      rdata_reg,
    // pair outputs
    output logic                                 masterPeriodEvent_reg,
    output logic                                 pwmOut_reg
);
    import pwm_pair_pkg::*;

    // ==========================================================
    // state
    typedef enum logic [1:0] {SLV_IDLE, SLV_ARMED, SLV_LOAD, SLV_COUNT} slaveState_t;

    slaveState_t       slaveState_reg;
    logic [1:0]        enable_reg;
    logic [CNT_W-1:0]  periodValue_reg;
    logic [CNT_W-1:0]  dutyValue_reg;
    logic [CNT_W-1:0]  masterCounter_reg;
    logic [CNT_W-1:0]  slaveCounter_reg;
    logic              outLevel_reg;
    logic              outEnable_reg;
    logic              outPolarity_reg;

    logic [1:0]        startPulse;
    logic [1:0]        stopPulse;
    logic              masterRun;
    logic              slaveRun;
    logic              masterHit;
    logic              slaveLoadNow;
    logic              slaveZeroNow;
    logic              outCtrlWrite;
    logic              slaveEndNow;
    logic              levelNext;
    logic              polarityNext;

    function automatic logic [CNT_W-1:0] cntDec(input logic [CNT_W-1:0] c);
        cntDec = c - CNT_ONE;
    endfunction : cntDec

    function automatic logic hitAddr(input regReq_t r, input logic [ADDR_W-1:0] a);
        hitAddr = (r.addr == a);
    endfunction : hitAddr

    // ==========================================================
    // trigger decode: triggers are pulses, never stored
    always_comb begin
        startPulse = 2'h0;
        stopPulse  = 2'h0;
        if (regReq.wr && hitAddr(regReq, OFF_START)) begin
            startPulse = regReq.wdata[1:0];
        end
        if (regReq.wr && hitAddr(regReq, OFF_STOP)) begin
            stopPulse = regReq.wdata[1:0];
        end
    end

    // stop takes effect in its own cycle so no extra step slips through
    assign masterRun    = enable_reg[BIT_MASTER] && !stopPulse[BIT_MASTER];
    assign slaveRun     = enable_reg[BIT_SLAVE] && !stopPulse[BIT_SLAVE];
    assign masterHit    = countClockTick && masterRun && (masterCounter_reg == CNT_ZERO);
    assign slaveLoadNow = countClockTick && slaveRun && (slaveState_reg == SLV_LOAD);
    assign slaveZeroNow = countClockTick && slaveRun && (slaveState_reg == SLV_COUNT)
                          && (slaveCounter_reg == CNT_ZERO);
    // pin drops as the count steps onto zero, so active ticks equal the duty
    assign slaveEndNow  = countClockTick && slaveRun && (slaveState_reg == SLV_COUNT)
                          && (slaveCounter_reg == CNT_ONE);
    assign outCtrlWrite = regReq.wr && hitAddr(regReq, OFF_OUTCTRL);

    // ==========================================================
    // enable status
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable_reg <= ENABLE_RST;
        end else begin
            // stop wins over a start in the same write
            enable_reg <= (enable_reg | startPulse) & ~stopPulse;
        end
    end

    // ==========================================================
    // period and duty values
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            periodValue_reg <= PERIOD_RST;
            dutyValue_reg   <= DUTY_RST;
        end else if (regReq.wr) begin
            // no shadow: mid-period writes land at the next reload
            if (hitAddr(regReq, OFF_PERIOD)) begin
                periodValue_reg <= regReq.wdata[CNT_W-1:0];
            end
            if (hitAddr(regReq, OFF_DUTY)) begin
                dutyValue_reg <= regReq.wdata[CNT_W-1:0];
            end
        end
    end

    // ==========================================================
    // slave output controls, writable while running
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outEnable_reg   <= OUTCTL_RST[BIT_OUTEN];
            outPolarity_reg <= OUTCTL_RST[BIT_POL];
        end else if (outCtrlWrite) begin
            outEnable_reg   <= regReq.wdata[BIT_OUTEN];
            outPolarity_reg <= regReq.wdata[BIT_POL];
        end
    end

    // ==========================================================
    // master counter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            masterCounter_reg <= MCOUNT_RST;
        end else if (startPulse[BIT_MASTER] && !stopPulse[BIT_MASTER]) begin
            masterCounter_reg <= periodValue_reg;
        end else if (masterHit) begin
            masterCounter_reg <= periodValue_reg;
        end else if (countClockTick && masterRun) begin
            masterCounter_reg <= cntDec(masterCounter_reg);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            masterPeriodEvent_reg <= 1'b0;
        end else begin
            masterPeriodEvent_reg <= masterHit;
        end
    end

    // ==========================================================
    // slave counter and its sequence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slaveState_reg   <= SLV_IDLE;
            slaveCounter_reg <= SCOUNT_RST;
        end else if (startPulse[BIT_SLAVE] && !stopPulse[BIT_SLAVE]) begin
            slaveState_reg <= SLV_ARMED;
        end else if (countClockTick && slaveRun) begin
            case (slaveState_reg)
                SLV_ARMED: begin
                    if (masterHit) begin
                        slaveState_reg <= SLV_LOAD;
                    end
                end
                SLV_LOAD: begin
                    slaveCounter_reg <= dutyValue_reg;
                    slaveState_reg   <= masterHit ? SLV_LOAD : SLV_COUNT;
                end
                SLV_COUNT: begin
                    if (slaveCounter_reg == CNT_ZERO) begin
                        slaveCounter_reg <= CNT_ONES;
                        slaveState_reg   <= masterHit ? SLV_LOAD : SLV_ARMED;
                    end else begin
                        slaveCounter_reg <= cntDec(slaveCounter_reg);
                        if (masterHit) begin
                            slaveState_reg <= SLV_LOAD;
                        end
                    end
                end
                default: begin
                    slaveState_reg <= SLV_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // output level; held as is when the pair stops
    // pin flop takes the next level, so it lags the event by one tick only
    always_comb begin
        levelNext = outLevel_reg;
        if (slaveLoadNow && outEnable_reg) begin
            // zero duty never goes active
            levelNext = (dutyValue_reg != CNT_ZERO);
        end else if (slaveEndNow && outEnable_reg) begin
            levelNext = 1'b0;
        end else if (outCtrlWrite && !outEnable_reg) begin
            // level bit only reaches the pin while output is disabled
            levelNext = regReq.wdata[BIT_LEVEL];
        end
    end

    assign polarityNext = outCtrlWrite ? regReq.wdata[BIT_POL] : outPolarity_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outLevel_reg <= OUTCTL_RST[BIT_LEVEL];
        end else begin
            outLevel_reg <= levelNext;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwmOut_reg <= 1'b0;
        end else begin
            pwmOut_reg <= levelNext ^ polarityNext;
        end
    end

    // ==========================================================
    // read port: data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (!regReq.rd) begin
            rdata_reg <= '0;
        end else begin
            case (regReq.addr)
                OFF_START:   rdata_reg <= '0;
                OFF_STOP:    rdata_reg <= '0;
                OFF_ENABLE:  rdata_reg <= DATA_W'(enable_reg);
                OFF_PERIOD:  rdata_reg <= DATA_W'(periodValue_reg);
                OFF_DUTY:    rdata_reg <= DATA_W'(dutyValue_reg);
                OFF_MCOUNT:  rdata_reg <= DATA_W'(masterCounter_reg);
                OFF_SCOUNT:  rdata_reg <= DATA_W'(slaveCounter_reg);
                OFF_OUTCTRL: rdata_reg <= DATA_W'({outPolarity_reg, outEnable_reg, outLevel_reg});
                default:     rdata_reg <= '0;
            endcase
        end
    end

    // ==========================================================
    // checks
    a_start_reads_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        (regReq.rd && regReq.addr == OFF_START) |=> (rdata_reg == '0))
        else $error("start trigger read back nonzero");

    a_start_loads_master: assert property (
        @(posedge clk_sys) disable iff (rst)
        (startPulse[BIT_MASTER] && !stopPulse[BIT_MASTER])
        |=> (enable_reg[BIT_MASTER] && masterCounter_reg == $past(periodValue_reg)))
        else $error("start did not enable and load master");

    a_event_at_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        (countClockTick && masterRun && masterCounter_reg == CNT_ZERO)
        |=> masterPeriodEvent_reg)
        else $error("no period event at master zero");

    a_event_only_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        masterPeriodEvent_reg |-> ($past(masterCounter_reg) == CNT_ZERO && $past(masterRun)))
        else $error("period event without master zero");

    a_master_reload: assert property (
        @(posedge clk_sys) disable iff (rst)
        masterHit |=> (masterCounter_reg == $past(periodValue_reg)))
        else $error("master did not reload on event");

    a_slave_loads: assert property (
        @(posedge clk_sys) disable iff (rst)
        (masterHit && slaveRun && slaveState_reg == SLV_ARMED && !startPulse[BIT_SLAVE])
        |=> (slaveState_reg == SLV_LOAD))
        else $error("slave not triggered by period event");

    a_slave_gets_duty: assert property (
        @(posedge clk_sys) disable iff (rst)
        (slaveLoadNow && !startPulse[BIT_SLAVE])
        |=> (slaveCounter_reg == $past(dutyValue_reg)))
        else $error("slave not loaded with duty");

    a_pwm_goes_active: assert property (
        @(posedge clk_sys) disable iff (rst)
        (slaveLoadNow && outEnable_reg && dutyValue_reg != CNT_ZERO)
        |=> (outLevel_reg && pwmOut_reg != outPolarity_reg))
        else $error("output not active one tick after event");

    a_slave_zero_ends: assert property (
        @(posedge clk_sys) disable iff (rst)
        (slaveZeroNow && !startPulse[BIT_SLAVE])
        |=> (slaveCounter_reg == CNT_ONES))
        else $error("slave did not park at all ones");

    a_slave_end_low: assert property (
        @(posedge clk_sys) disable iff (rst)
        (slaveEndNow && outEnable_reg && !startPulse[BIT_SLAVE])
        |=> (!outLevel_reg && slaveCounter_reg == CNT_ZERO))
        else $error("pulse did not end as slave reached zero");

    a_master_steps: assert property (
        @(posedge clk_sys) disable iff (rst)
        (countClockTick && masterRun && masterCounter_reg != CNT_ZERO && !startPulse[BIT_MASTER])
        |=> (masterCounter_reg == $past(masterCounter_reg) - CNT_ONE))
        else $error("master did not step by one");

    a_hold_between: assert property (
        @(posedge clk_sys) disable iff (rst)
        ((!countClockTick || !masterRun) && !startPulse[BIT_MASTER])
        |=> $stable(masterCounter_reg))
        else $error("master moved without a tick");

    a_stop_clears: assert property (
        @(posedge clk_sys) disable iff (rst)
        stopPulse[BIT_SLAVE] |=> (!enable_reg[BIT_SLAVE] && $stable(slaveCounter_reg)))
        else $error("stop did not halt slave");

    a_read_master: assert property (
        @(posedge clk_sys) disable iff (rst)
        (regReq.rd && regReq.addr == OFF_MCOUNT)
        |=> (rdata_reg[CNT_W-1:0] == $past(masterCounter_reg)))
        else $error("master count readback wrong");

    a_read_slave: assert property (
        @(posedge clk_sys) disable iff (rst)
        (regReq.rd && regReq.addr == OFF_SCOUNT)
        |=> (rdata_reg[CNT_W-1:0] == $past(slaveCounter_reg)))
        else $error("slave count readback wrong");

    a_stop_reads_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        (regReq.rd && regReq.addr == OFF_STOP) |=> (rdata_reg == '0))
        else $error("stop trigger read back nonzero");

    a_stop_holds_level: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!enable_reg[BIT_SLAVE] && !outCtrlWrite)
        |=> $stable(outLevel_reg))
        else $error("output level moved while stopped");

endmodule : pwm_pair

// >>> testbench/tb.sv
// self-checking bench for the master/slave pwm channel pair
// assumes pwm_pair and pwm_pair_pkg compiled first; the bench drives every port itself
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_pair_pkg::*;

    // ==========================================================
    // signals and design instance
    logic              clk_sys;
    logic              rst;
    logic              countClockTick;
    regReq_t           regReq;
    logic [DATA_W-1:0] rdata;
    logic              periodEvent;
    logic              pwmOut;
    int                badCount;
    int                numChecks;

    pwm_pair pwm_pair_i (
        .clk_sys               (clk_sys),
        .rst                   (rst),
        .countClockTick        (countClockTick),
        .regReq                (regReq),
        .rdata_reg             (rdata),
        .masterPeriodEvent_reg (periodEvent),
        .pwmOut_reg            (pwmOut)
    );

    always #12.5 clk_sys = ~clk_sys;

    // ==========================================================
    // bus and compare helpers
    task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        regReq.wr    <= 1'b1;
        regReq.addr  <= a;
        regReq.wdata <= d;
        @(posedge clk_sys);
        regReq.wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk_sys);
        regReq.rd   <= 1'b1;
        regReq.addr <= a;
        @(posedge clk_sys);
        regReq.rd   <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    // two reads on consecutive edges, so the pair sees one count step
    task automatic rdd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v1,
                       output logic [DATA_W-1:0] v2);
        @(posedge clk_sys);
        regReq.rd   <= 1'b1;
        regReq.addr <= a;
        @(posedge clk_sys);
        #1;
        v1 = rdata;
        @(posedge clk_sys);
        regReq.rd   <= 1'b0;
        #1;
        v2 = rdata;
    endtask : rdd

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] v;
        rd(a, v);
        chk(what, exp, v);
    endtask : rdchk

    // returns one step after the edge that raised the event
    task automatic waitEvt;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            #1;
            if (periodEvent === 1'b1) return;
        end
        chk("event wait", 32'h1, 32'h0);
    endtask : waitEvt

    // ==========================================================
    // scenarios
    task automatic t_reset;
        rdchk("enable", OFF_ENABLE, 32'h0);
        rdchk("mcount", OFF_MCOUNT, 32'h0000ffff);
        rdchk("scount", OFF_SCOUNT, 32'h0000ffff);
        rdchk("period", OFF_PERIOD, 32'h0);
        wr(8'h40, 32'h0000abcd);
        rdchk("unmapped", 8'h40, 32'h0);
    endtask : t_reset

    task automatic t_start;
        int  n;
        logic sawLow;
        wr(OFF_PERIOD, 32'h3);
        wr(OFF_DUTY, 32'h1);
        wr(OFF_OUTCTRL, 32'h2);
        wr(OFF_START, 32'h3);
        rdchk("mcount load", OFF_MCOUNT, 32'h3);
        rdchk("enable on", OFF_ENABLE, 32'h3);
        rdchk("start self clear", OFF_START, 32'h0);
        rdchk("mcount hold", OFF_MCOUNT, 32'h3);
        @(posedge clk_sys);
        countClockTick <= 1'b1;
        waitEvt();
        chk("pwm before", 32'h0, {31'h0, pwmOut});
        @(posedge clk_sys);
        #1;
        chk("pwm active", 32'h1, {31'h0, pwmOut});
        chk("event one cycle", 32'h0, {31'h0, periodEvent});
        n = 1;
        sawLow = 1'b0;
        while (periodEvent !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (pwmOut === 1'b0) sawLow = 1'b1;
        end
        chk("period ticks", 32'd4, n);
        chk("pwm inactive", 32'h1, {31'h0, sawLow});
    endtask : t_start

    task automatic t_counts;
        logic [DATA_W-1:0] v1;
        logic [DATA_W-1:0] v2;
        waitEvt();
        wr(OFF_PERIOD, 32'd100);
        wr(OFF_DUTY, 32'd5);
        waitEvt();
        waitEvt();
        rdd(OFF_SCOUNT, v1, v2);
        chk("scount duty", 32'd5, v1);
        chk("scount step", v1 - 32'h1, v2);
        rdd(OFF_MCOUNT, v1, v2);
        chk("mcount read", 32'd96, v1);
        chk("mcount step", v1 - 32'h1, v2);
        repeat (20) @(posedge clk_sys);
        rdchk("scount parked", OFF_SCOUNT, 32'h0000ffff);
        chk("pwm low", 32'h0, {31'h0, pwmOut});
    endtask : t_counts

    task automatic t_pol;
        waitEvt();
        wr(OFF_DUTY, 32'h0);
        waitEvt();
        waitEvt();
        repeat (5) @(posedge clk_sys);
        wr(OFF_OUTCTRL, 32'h6);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("pwm inverted", 32'h1, {31'h0, pwmOut});
    endtask : t_pol

    task automatic t_stop;
        logic [DATA_W-1:0] m;
        logic [DATA_W-1:0] s;
        logic              p;
        logic              ev;
        wr(OFF_STOP, 32'h3);
        rdchk("enable off", OFF_ENABLE, 32'h0);
        rdchk("stop self clear", OFF_STOP, 32'h0);
        p = pwmOut;
        rd(OFF_MCOUNT, m);
        rd(OFF_SCOUNT, s);
        ev = 1'b0;
        repeat (10) begin
            @(posedge clk_sys);
            #1;
            if (periodEvent === 1'b1) ev = 1'b1;
        end
        chk("no event stopped", 32'h0, {31'h0, ev});
        rdchk("mcount kept", OFF_MCOUNT, m);
        rdchk("scount kept", OFF_SCOUNT, s);
        chk("pwm kept", {31'h0, p}, {31'h0, pwmOut});
    endtask : t_stop

    task automatic t_restart;
        @(posedge clk_sys);
        countClockTick <= 1'b0;
        wr(OFF_OUTCTRL, 32'h2);
        wr(OFF_START, 32'h3);
        rdchk("mcount reload", OFF_MCOUNT, 32'd100);
        rdchk("enable again", OFF_ENABLE, 32'h3);
    endtask : t_restart

    // ==========================================================
    // run control
    task automatic conclude;
        $display("checks %0d errors %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // whole run needs well under a thousand cycles; the 20000-cycle limit leaves wide margin
    initial begin
        #500000;
        badCount++;
        conclude();
    end

    initial begin
        clk_sys        = 1'b0;
        rst            = 1'b1;
        countClockTick = 1'b0;
        regReq         = '0;
        badCount       = 0;
        numChecks      = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_start();
        t_counts();
        t_pol();
        t_stop();
        t_restart();
        conclude();
    end
endmodule : tb
